//--- logic/cfs_supervisor.sv
// Card fault supervisor: fault monitors, presence status pin, emergency deactivation.
// Assumes pin and comparator inputs are asynchronous; fault inputs are active high.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_cfg.svh"

module cfs_supervisor #(
   parameter logic [15:0] OSC_LOW_DIV = 16'(`CFS_OSC_LOW_DIV),
   parameter logic [10:0] DEB_PERIODS = 11'(`CFS_DEB_OSC_PERIODS)
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Host and card pins, monitor comparators
   input wire cfs_pkg::cfs_pins_t pins,
   // Status pin toward host
   output logic faultPresenceN,
   output logic faultPresenceOe,
   // Card contact enables and events
   output cfs_pkg::cfs_card_t card,
   output logic deactStart,
   output logic porPulse
);

   localparam cfs_pkg::cfs_pins_t PINS_IDLE = '{sessReqN: 1'b1, cardPresN: 1'b1, chipSel: 1'b1,
      en5v3vN: 1'b1, en18vN: 1'b1, default: 1'b0};

   cfs_pkg::cfs_sup_st_t st;
   cfs_pkg::cfs_sup_st_t next_st;
   logic dbPresent;
   logic anyFault;
   logic sessionLow;
   logic deep;
   logic hiTick;

   function automatic logic stepDone(input logic [6:0] step, input logic [6:0] gap);
      stepDone = (step == 7'(gap - 7'h01));
   endfunction

   cfs_debounce #(
      .OSC_LOW_DIV(OSC_LOW_DIV),
      .DEB_PERIODS(DEB_PERIODS)
   ) u_debounce (
      .sys_clk(sys_clk),
      .rst(rst),
      .cardPresN(st.s2.cardPresN),
      .present(dbPresent)
   );

   // Removal counts at once since debounce drops presence without delay
   assign anyFault = st.s2.overCurrent | st.s2.overTemp | st.s2.convLow | st.s2.intfLow | st.s2.regLow
      | !dbPresent;
   assign sessionLow = !st.hold.sessReqN;
   assign deep = st.hold.sessReqN & !st.hold.en5v3vN & !st.hold.en18vN & (st.seq == cfs_pkg::SEQ_IDLE);
   assign hiTick = (st.hiDiv == 16'(`CFS_OSC_HIGH_DIV - 16'h0001));

   assign faultPresenceN = st.fpN;
   assign faultPresenceOe = st.fpOe;
   assign card = st.card;
   assign deactStart = st.deactStart;
   assign porPulse = st.porPulse;

   always_comb begin
      next_st = st;
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      // Host controls frozen while deselected
      next_st.hold = st.s2.chipSel ? st.s2 : st.hold;
      next_st.fpOe = st.s2.chipSel;
      next_st.deactStart = 1'b0;
      next_st.convLowPrev = st.s2.convLow;
      next_st.porPulse = st.s2.convLow & !st.convLowPrev & st.hold.sessReqN;
      next_st.hiDiv = 16'h0000;
      // Fault memory: set can only occur while the clear term is false
      if (sessionLow && anyFault) begin
         next_st.faultLatched = 1'b1;
      end else if (st.hold.sessReqN) begin
         next_st.faultLatched = 1'b0;
      end
      if (deep) begin
         next_st.fpN = !st.s2.cardPresN;
      end else if (sessionLow) begin
         next_st.fpN = !(anyFault || st.faultLatched);
      end else begin
         // Supply monitors ignored here: card is unpowered
         next_st.fpN = dbPresent;
      end
      case (st.seq)
         cfs_pkg::SEQ_IDLE: begin
            next_st.done = 1'b0;
            if (sessionLow && !st.done) begin
               next_st.seq = cfs_pkg::SEQ_ACTIVE;
               next_st.card = '{default: 1'b1};
            end else if (!sessionLow) begin
               // Host must raise session request before a new session
               next_st.done = 1'b0;
            end else begin
               next_st.done = 1'b1;
            end
         end
         cfs_pkg::SEQ_ACTIVE: begin
            if (st.hold.sessReqN || anyFault) begin
               next_st.seq = cfs_pkg::SEQ_WAIT_RST;
               next_st.step = 7'h00;
               next_st.deactStart = 1'b1;
            end
         end
         cfs_pkg::SEQ_WAIT_RST,
         cfs_pkg::SEQ_WAIT_CLK,
         cfs_pkg::SEQ_WAIT_IO,
         cfs_pkg::SEQ_WAIT_VCC: begin
            next_st.hiDiv = hiTick ? 16'h0000 : 16'(st.hiDiv + 16'h0001);
            if (hiTick) begin
               next_st.step = 7'(st.step + 7'h01);
               if (st.seq == cfs_pkg::SEQ_WAIT_RST && stepDone(st.step, `CFS_STEP_RST)) begin
                  next_st.card.rstEn = 1'b0;
                  next_st.step = 7'h00;
                  next_st.seq = cfs_pkg::SEQ_WAIT_CLK;
               end else if (st.seq == cfs_pkg::SEQ_WAIT_CLK && stepDone(st.step, `CFS_STEP_HALF_T)) begin
                  next_st.card.clkEn = 1'b0;
                  next_st.step = 7'h00;
                  next_st.seq = cfs_pkg::SEQ_WAIT_IO;
               end else if (st.seq == cfs_pkg::SEQ_WAIT_IO && stepDone(st.step, `CFS_STEP_HALF_T)) begin
                  next_st.card.ioEn = 1'b0;
                  next_st.step = 7'h00;
                  next_st.seq = cfs_pkg::SEQ_WAIT_VCC;
               end else if (st.seq == cfs_pkg::SEQ_WAIT_VCC && stepDone(st.step, `CFS_STEP_HALF_T)) begin
                  next_st.card.vccEn = 1'b0;
                  next_st.step = 7'h00;
                  next_st.seq = cfs_pkg::SEQ_IDLE;
                  // No re-activation until session request has been high
                  next_st.done = sessionLow;
               end
            end
         end
         default: begin
            next_st.seq = cfs_pkg::SEQ_IDLE;
            next_st.card = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st <= '{s1: PINS_IDLE, s2: PINS_IDLE, hold: PINS_IDLE, seq: cfs_pkg::SEQ_IDLE, fpOe: 1'b1, default: '0};
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_rst_drop;
      $fell(st.card.rstEn);
   endsequence
   sequence s_clk_stop;
      $fell(st.card.clkEn);
   endsequence
   sequence s_io_low;
      $fell(st.card.ioEn);
   endsequence
   sequence s_vcc_off;
      $fell(st.card.vccEn);
   endsequence

   chk_fault_sources: assert property (st.seq == cfs_pkg::SEQ_ACTIVE && sessionLow
         && (st.s2.overTemp || st.s2.intfLow || st.s2.regLow) |=> st.faultLatched)
      else $error("monitored fault not latched in session");
   chk_idle_presence: assert property (st.hold.sessReqN && !deep |=> st.fpN == $past(dbPresent))
      else $error("status does not show presence outside session");
   chk_por_pulse: assert property ($rose(st.s2.convLow) && st.hold.sessReqN |=> st.porPulse)
      else $error("no reset pulse on converter supply drop");
   chk_no_oc_report: assert property (st.hold.sessReqN && !deep && dbPresent
         && (st.s2.overCurrent || st.s2.overTemp) |=> st.fpN)
      else $error("overcurrent reported outside session");
   chk_fault_low: assert property (sessionLow && anyFault |=> !st.fpN)
      else $error("session fault not shown on status");
   chk_emergency_start: assert property (st.seq == cfs_pkg::SEQ_ACTIVE && anyFault
         |=> st.seq == cfs_pkg::SEQ_WAIT_RST && st.deactStart)
      else $error("emergency deactivation not started");
   chk_clk_after_rst: assert property (s_clk_stop |-> !st.card.rstEn && st.card.ioEn)
      else $error("clock stopped out of order");
   chk_io_after_clk: assert property (s_io_low |-> !st.card.clkEn && st.card.vccEn)
      else $error("data lines dropped out of order");
   chk_vcc_last: assert property (s_vcc_off |-> !st.card.ioEn && !st.card.rstEn)
      else $error("supply removed out of order");
   chk_rst_first: assert property (s_rst_drop |-> st.card.clkEn && st.seq == cfs_pkg::SEQ_WAIT_CLK)
      else $error("reset drop not first step");
   chk_deep_follow: assert property (deep |=> st.fpN == !$past(st.s2.cardPresN))
      else $error("status not following presence in deep mode");
   chk_cs_float: assert property (!st.s2.chipSel |=> !st.fpOe && st.hold == $past(st.hold))
      else $error("deselect did not float status or latch inputs");
   chk_fault_hold: assert property (st.faultLatched && sessionLow |=> !st.fpN)
      else $error("latched fault released during session");
   chk_latch_clear: assert property (st.hold.sessReqN |=> !st.faultLatched)
      else $error("fault memory kept after session request high");
   chk_release_status: assert property ($rose(st.hold.sessReqN) && dbPresent && !deep |=> st.fpN)
      else $error("status not restored after session ends");
   chk_removal_deact: assert property (st.seq == cfs_pkg::SEQ_ACTIVE && $fell(dbPresent) |=> st.deactStart)
      else $error("card removal did not start deactivation");
   chk_start_single: assert property (st.deactStart |=> !st.deactStart)
      else $error("deactivation start pulse longer than one cycle");

endmodule
`default_nettype wire

//--- common/cfs_cfg.svh
// Timing counts and step figures for the card fault supervisor.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef CFS_CFG_SVH
`define CFS_CFG_SVH

// System clock period in ns
`define CFS_CLK_PERIOD_NS 32'h0000_000A
// Presence debounce time in ns, and the same in low-rate oscillator periods
`define CFS_DEB_TIME_NS 32'h003D_CC50
`define CFS_DEB_OSC_PERIODS 32'h0000_0500
// Clock cycles per low-rate oscillator period, derived from the debounce time
`define CFS_OSC_LOW_DIV (`CFS_DEB_TIME_NS / `CFS_DEB_OSC_PERIODS / `CFS_CLK_PERIOD_NS)
// Clock cycles per high-rate oscillator period, T/64 of the sequencer
`define CFS_OSC_HIGH_DIV 16'h0020
// Deactivation step gaps in T/64 ticks: 3T/64, then T/2 each
`define CFS_STEP_RST 7'h03
`define CFS_STEP_HALF_T 7'h20

`endif

//--- common/cfs_pkg.sv
// Types shared by the card fault supervisor modules.
// Assumes the constants of cfs_cfg.svh.
`default_nettype none

package cfs_pkg;

   typedef struct packed {
      logic sessReqN;
      logic cardPresN;
      logic chipSel;
      logic en5v3vN;
      logic en18vN;
      logic overCurrent;
      logic overTemp;
      logic convLow;
      logic intfLow;
      logic regLow;
   } cfs_pins_t;

   typedef struct packed {
      logic rstEn;
      logic clkEn;
      logic ioEn;
      logic vccEn;
   } cfs_card_t;

   typedef enum logic [5:0] {
      SEQ_IDLE = 6'b00_0001,
      SEQ_ACTIVE = 6'b00_0010,
      SEQ_WAIT_RST = 6'b00_0100,
      SEQ_WAIT_CLK = 6'b00_1000,
      SEQ_WAIT_IO = 6'b01_0000,
      SEQ_WAIT_VCC = 6'b10_0000
   } cfs_seq_t;

   typedef struct packed {
      logic [15:0] div;
      logic [10:0] cnt;
      logic present;
   } cfs_deb_st_t;

   typedef struct packed {
      cfs_pins_t s1;
      cfs_pins_t s2;
      cfs_pins_t hold;
      cfs_seq_t seq;
      logic done;
      logic [15:0] hiDiv;
      logic [6:0] step;
      logic faultLatched;
      logic fpN;
      logic fpOe;
      logic convLowPrev;
      logic porPulse;
      logic deactStart;
      cfs_card_t card;
   } cfs_sup_st_t;

endpackage
`default_nettype wire

//--- logic/cfs_debounce.sv
// Card presence debounce on the low-rate internal oscillator.
// Assumes cardPresN is already synchronised to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "cfs_cfg.svh"

module cfs_debounce #(
   parameter logic [15:0] OSC_LOW_DIV = 16'(`CFS_OSC_LOW_DIV),
   parameter logic [10:0] DEB_PERIODS = 11'(`CFS_DEB_OSC_PERIODS)
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Presence
   input wire logic cardPresN,
   output logic present
);

   cfs_pkg::cfs_deb_st_t st;
   cfs_pkg::cfs_deb_st_t next_st;
   logic tick;

   assign tick = (st.div == 16'(OSC_LOW_DIV - 16'h0001));
   assign present = st.present;

   always_comb begin
      next_st = st;
      next_st.div = tick ? 16'h0000 : 16'(st.div + 16'h0001);
      if (cardPresN) begin
         // Removal is taken at once, no filtering
         next_st.cnt = 11'h000;
         next_st.present = 1'b0;
      end else if (!st.present && tick) begin
         next_st.cnt = 11'(st.cnt + 11'h001);
         if (st.cnt == 11'(DEB_PERIODS - 11'h001)) begin
            next_st.present = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_extract_fast: assert property (cardPresN |=> !st.present)
      else $error("presence kept after card removal");
   chk_insert_full: assert property ($rose(st.present) |->
         $past(st.cnt) == 11'(DEB_PERIODS - 11'h001) && $past(tick) && !$past(cardPresN))
      else $error("presence accepted before full debounce");
   chk_deb_count: assert property (!st.present && !cardPresN && tick |=> st.cnt == 11'($past(st.cnt) + 11'h001))
      else $error("debounce count did not advance on oscillator tick");

endmodule
`default_nettype wire

//--- tb/cfs_host_model.sv
// Host-side partner: drives session request, chip select and supply selects; reads the status pin.
// Assumes the bench sets its wish inputs at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module cfs_host_model (
   // Clock
   input wire logic sys_clk,
   // Wishes from the bench
   input wire logic wantSession,
   input wire logic wantSelect,
   input wire logic wantDeep,
   // Status pin from the device
   input wire logic statusN,
   input wire logic statusOe,
   // Host pins toward the device, and the status as the host reads it, for the bench
   output logic sessReqN,
   output logic chipSel,
   output logic en5v3vN,
   output logic en18vN,
   output logic statusSeen
);
   logic lastSeen = 1'h0;

   // No pull on the pin: a floated status reads as the inverse of its last value
   assign statusSeen = statusOe ? statusN : !lastSeen;

   always @(posedge sys_clk) begin
      if (statusOe) begin
         lastSeen <= statusN;
      end
   end

   // Pins follow the wishes directly: a second falling-edge process would race the bench
   assign sessReqN = !wantSession;
   assign chipSel = wantSelect;
   assign en5v3vN = !wantDeep;
   assign en18vN = !wantDeep;
endmodule

`default_nettype wire

//--- tb/cfs_supervisor_test.sv
// Bench for the card fault supervisor: scenarios, comparisons and verdict.
// Assumes the host model and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module cfs_supervisor_test;
   logic sys_clk = 1'h0;
   logic rst = 1'h1;
   logic cardPresN = 1'h1;
   logic [4:0] flt = 5'h0;
   logic wSess = 1'h0;
   logic wSel = 1'h1;
   logic wDeep = 1'h0;
   logic sessReqN, chipSel, en5v3vN, en18vN, fpN, fpOe, deact, por, seen;
   logic [3:0] cardBits;
   cfs_pkg::cfs_pins_t pins;
   cfs_pkg::cfs_card_t card;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   int n;

   assign pins = {sessReqN, cardPresN, chipSel, en5v3vN, en18vN, flt};
   assign cardBits = card;

   always #5 sys_clk = ~sys_clk;

   // Short debounce so an insertion takes tens of cycles, not 400k
   cfs_supervisor #(.OSC_LOW_DIV(16'h0004), .DEB_PERIODS(11'h008)) DUT (.sys_clk(sys_clk), .rst(rst),
      .pins(pins), .faultPresenceN(fpN), .faultPresenceOe(fpOe), .card(card), .deactStart(deact),
      .porPulse(por));

   cfs_host_model host (.sys_clk(sys_clk), .wantSession(wSess), .wantSelect(wSel), .wantDeep(wDeep),
      .statusN(fpN), .statusOe(fpOe), .sessReqN(sessReqN), .chipSel(chipSel), .en5v3vN(en5v3vN),
      .en18vN(en18vN), .statusSeen(seen));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) @(negedge sys_clk);
   endtask

   // Run is about 20k cycles; twice that means a hang
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         conclude();
      end
   end

   task automatic waitDeact();
      n = 0;
      while (deact !== 1'h1 && n < 8) begin
         tick(1);
         n++;
      end
      check(deact, 1'h1);
   endtask

   task automatic gap(input int b, input int lo, input int hi);
      n = 0;
      while (cardBits[b] !== 1'h0 && n < 2000) begin
         tick(1);
         n++;
      end
      check(n >= lo && n <= hi, 1'h1);
   endtask

   // Callers enter at different points after the start pulse, so the first step gets a window
   task automatic deactSteps();
      gap(3, 64, 128);
      gap(2, 1024, 1024);
      gap(1, 1024, 1024);
      gap(0, 1024, 1024);
   endtask

   task automatic t_reset();
      check(fpN, 1'h0);
      check(fpOe, 1'h1);
      check(cardBits, 4'h0);
      check(deact, 1'h0);
      $display("reset test done");
   endtask

   task automatic t_insert();
      cardPresN = 1'h0;
      n = 0;
      while (seen !== 1'h1 && n < 100) begin
         tick(1);
         n++;
      end
      check(n >= 32 && n <= 44, 1'h1);
      check(seen, 1'h1);
      $display("insertion test done");
   endtask

   task automatic t_idle_faults();
      flt = 5'h18;
      tick(6);
      check(seen, 1'h1);
      flt = 5'h04;
      n = 0;
      while (por !== 1'h1 && n < 8) begin
         tick(1);
         n++;
      end
      check(por, 1'h1);
      check(seen, 1'h1);
      flt = 5'h00;
      tick(4);
      $display("idle fault test done");
   endtask

   task automatic t_fault(input int f);
      wSess = 1'h1;
      tick(8);
      check(cardBits, 4'hf);
      flt[f] = 1'h1;
      waitDeact();
      check(seen, 1'h0);
      tick(1);
      flt[f] = 1'h0;
      tick(10);
      check(seen, 1'h0);
      deactSteps();
      wSess = 1'h0;
      tick(8);
      check(seen, 1'h1);
      $display("session fault %0d test done", f);
   endtask

   task automatic t_removal();
      cardPresN = 1'h1;
      tick(4);
      check(seen, 1'h0);
      cardPresN = 1'h0;
      tick(50);
      wSess = 1'h1;
      tick(8);
      cardPresN = 1'h1;
      waitDeact();
      check(seen, 1'h0);
      deactSteps();
      wSess = 1'h0;
      tick(8);
      check(seen, 1'h0);
      $display("removal test done");
   endtask

   task automatic t_chipsel();
      wSel = 1'h0;
      tick(4);
      check(fpOe, 1'h0);
      wSess = 1'h1;
      tick(8);
      check(cardBits, 4'h0);
      wSess = 1'h0;
      wSel = 1'h1;
      tick(6);
      check(fpOe, 1'h1);
      $display("chip select test done");
   endtask

   task automatic t_deep();
      wDeep = 1'h1;
      tick(6);
      check(seen, 1'h0);
      cardPresN = 1'h0;
      tick(5);
      check(seen, 1'h1);
      cardPresN = 1'h1;
      tick(5);
      check(seen, 1'h0);
      wDeep = 1'h0;
      $display("deep mode test done");
   endtask

   initial begin
      tick(4);
      rst = 1'h0;
      tick(1);
      t_reset();
      t_insert();
      t_idle_faults();
      for (int f = 0; f < 5; f++) begin
         t_fault(f);
      end
      t_removal();
      t_chipsel();
      t_deep();
      conclude();
   end
endmodule

`default_nettype wire
